// >>> shared/epe_pkg.sv
// package for the ecp parallel port engine: offsets, fields, modes, carriers
package epe_pkg;
   localparam logic [10:0] ADDR_AFIFO = 11'h000;
   localparam logic [10:0] ADDR_DATA = 11'h000;
   localparam logic [10:0] ADDR_DSR = 11'h001;
   localparam logic [10:0] ADDR_DCR = 11'h002;
   localparam logic [10:0] ADDR_DFIFO = 11'h400;
   localparam logic [10:0] ADDR_CNFGB = 11'h401;
   localparam logic [10:0] ADDR_ECR = 11'h402;
   localparam int ECR_MODE_HI = 7;
   localparam int ECR_MODE_LO = 5;
   localparam int ECR_NERR = 4;
   localparam int ECR_DMA_ON = 3;
   localparam int ECR_SVC = 2;
   localparam int ECR_FULL = 1;
   localparam int ECR_EMPTY = 0;
   localparam int DCR_DIR = 5;
   localparam int DCR_ACKIE = 4;
   localparam int DCR_SELIN = 3;
   localparam int DCR_INIT = 2;
   localparam int DCR_AFD = 1;
   localparam int DCR_STB = 0;
   localparam logic [7:0] ECR_RESET = 8'h15;
   localparam logic [7:0] DCR_RESET = 8'h04;
   localparam logic [7:0] CNFGA_VALUE = 8'h10;
   localparam logic [7:0] CNFGB_CONST = 8'h07;
   localparam logic [7:0] DSR_LOW_ONES = 8'h07;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   localparam logic [4:0] FIFO_DEPTH_C = 5'h10;
   localparam logic [4:0] WRITE_THRESH = 5'h08;
   localparam logic [4:0] READ_THRESH = 5'h08;
   localparam int HOLD_NS = 16;
   localparam int CLK_NS = 8;
   localparam logic [1:0] HOLD_CYC = 2'((HOLD_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [2:0] {
      EPE_SPP = 3'h0, EPE_PS2 = 3'h1, EPE_PFIFO = 3'h2, EPE_ECP = 3'h3,
      EPE_EPP = 3'h4, EPE_RSVD = 3'h5, EPE_TEST = 3'h6, EPE_CFG = 3'h7
   } epe_mode_e;

   // one fifo entry: byte plus command flag
   typedef struct packed {
      logic cmd;
      logic [7:0] data;
   } epe_entry_s;

   // host i/o bus request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [10:0] addr;
      logic [7:0] wdata;
   } epe_io_s;

   // floppy controller side signals
   typedef struct packed {
      logic drive_a_motor_out;
      logic drive_a_select_out;
      logic drive_b_motor_out;
      logic drive_b_select_out;
   } epe_fdd_out_s;
endpackage : epe_pkg

// >>> design/epe_port.sv
// ecp parallel port engine: registers, shared fifo, ecp handshake, dma, floppy modes
`timescale 1ns/1ns
module epe_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host i/o
   input wire epe_pkg::epe_io_s io,
   output logic [7:0] io_rdata,
   // dma
   output logic dma_request_pin,
   input wire logic dma_ack,
   input wire logic dma_tc,
   output logic irq,
   // printer pins
   input wire logic [7:0] pd_in,
   output logic [7:0] pd_out,
   output logic pd_oe,
   output logic n_strobe,
   output logic n_autofd,
   output logic n_init,
   output logic n_selectin,
   input wire logic n_ack,
   input wire logic busy,
   input wire logic perror,
   input wire logic select,
   input wire logic n_fault,
   // floppy extension
   input wire logic single_extension_floppy_mode,
   input wire logic dual_extension_floppy_mode,
   input wire epe_pkg::epe_fdd_out_s fdc_out,
   input wire logic [4:0] fdd_status_pins,
   output epe_pkg::epe_fdd_out_s fdd_out,
   output logic [4:0] fdc_status_in
);
   import epe_pkg::*;

   epe_mode_e mode;
   logic [7:0] dcr;
   logic [7:0] data_reg;
   logic nerr_en, dma_enable_bit, service_flag;
   epe_entry_s fifo_mem [FIFO_DEPTH];
   logic [FIFO_AW-1:0] wr_ptr, rd_ptr;
   logic [4:0] count;
   logic fifo_full, fifo_empty, fifo_push, fifo_pop;
   epe_entry_s push_entry, head;
   logic [7:0] rle_left;
   logic n_fault_d, n_ack_d;
   logic dir, fifo_on, ecp_fwd, ecp_rev, pfifo_fwd;
   logic host_wr_fifo, host_rd_fifo, dma_xfer;
   logic [7:0] wval;

   typedef enum logic [2:0] {EPE_IDLE, EPE_SETUP, EPE_STROBE, EPE_WAIT_REL, EPE_REV_WAIT, EPE_REV_ACK} epe_hs_e;
   epe_hs_e hs;
   logic [1:0] hold_cnt;
   epe_entry_s out_byte;

   assign dir = dcr[DCR_DIR];
   assign fifo_on = (mode == EPE_PFIFO) || (mode == EPE_ECP) || (mode == EPE_TEST);
   assign ecp_fwd = (mode == EPE_ECP) && !dir && perror;
   assign ecp_rev = (mode == EPE_ECP) && dir;
   assign pfifo_fwd = (mode == EPE_PFIFO);
   assign fifo_full = (count == FIFO_DEPTH_C);
   assign fifo_empty = (count == 5'h00);
   assign head = fifo_mem[rd_ptr];
   assign wval = io.wdata;

   // dma moves bytes only through the data/compatible/test fifo
   assign dma_xfer = dma_ack && dma_enable_bit && !service_flag && fifo_on;
   assign host_wr_fifo = io.wr && fifo_on && (io.addr == ADDR_DFIFO || (io.addr == ADDR_AFIFO && mode == EPE_ECP));
   assign host_rd_fifo = io.rd && fifo_on && io.addr == ADDR_DFIFO;

   always_comb begin
      push_entry = '{cmd: 1'b0, data: wval};
      fifo_push = 1'b0;
      if (ecp_rev && hs == EPE_REV_WAIT && !n_ack) begin
         push_entry = '{cmd: ~busy, data: pd_in};
         fifo_push = !fifo_full;
      end else if (host_wr_fifo || (dma_xfer && !dir)) begin
         push_entry = '{cmd: (io.addr == ADDR_AFIFO) && !dma_xfer, data: wval};
         fifo_push = !fifo_full;
      end
   end

   always_comb begin
      fifo_pop = 1'b0;
      if (host_rd_fifo || (dma_xfer && dir)) begin
         fifo_pop = !fifo_empty;
      end else if (hs == EPE_IDLE && !fifo_empty && (ecp_fwd || pfifo_fwd) && rle_left == 8'h00) begin
         // run-length commands stay queued until their data byte follows them in the fifo
         fifo_pop = !(head.cmd && !head.data[7] && count < 5'h02);
      end
   end

   // shared sixteen-byte fifo
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (!fifo_on) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (fifo_push) wr_ptr <= wr_ptr + 1'b1;
         if (fifo_pop) rd_ptr <= rd_ptr + 1'b1;
         count <= 5'(count + {4'h0, fifo_push} - {4'h0, fifo_pop});
      end
   end

   always_ff @(posedge core_clk) begin
      if (fifo_push) fifo_mem[wr_ptr] <= push_entry;
   end

   // ecr, dcr and data register writes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode <= EPE_SPP;
         nerr_en <= ECR_RESET[ECR_NERR];
         dma_enable_bit <= ECR_RESET[ECR_DMA_ON];
         service_flag <= ECR_RESET[ECR_SVC];
         dcr <= DCR_RESET;
         data_reg <= 8'h00;
      end else begin
         if (io.wr && io.addr == ADDR_ECR) begin
            if (mode == EPE_SPP || mode == EPE_PS2 || wval[7:5] == 3'h0 || wval[7:5] == 3'h1)
               mode <= epe_mode_e'(wval[ECR_MODE_HI:ECR_MODE_LO]);
            nerr_en <= wval[ECR_NERR];
            dma_enable_bit <= wval[ECR_DMA_ON];
            service_flag <= wval[ECR_SVC];
         end
         if (io.wr && io.addr == ADDR_DCR) begin
            dcr[DCR_ACKIE:0] <= wval[DCR_ACKIE:0];
            if (mode == EPE_PS2) dcr[DCR_DIR] <= wval[DCR_DIR];
         end
         if (io.wr && io.addr == ADDR_DATA && (mode == EPE_SPP || mode == EPE_PS2)) data_reg <= wval;
         // hardware sets the service flag; a set wins over a clear in the same cycle
         if (dma_enable_bit && dma_tc && dma_ack) service_flag <= 1'b1;
         else if (!dma_enable_bit && fifo_on && !dir && (5'(FIFO_DEPTH_C - count) >= WRITE_THRESH))
            service_flag <= 1'b1;
         else if (!dma_enable_bit && fifo_on && dir && count >= READ_THRESH) service_flag <= 1'b1;
         // falling nFault in forward ecp sets the nerr_en bit as the interrupt is taken
         if (mode == EPE_ECP && !dir && !nerr_en && n_fault_d && !n_fault) nerr_en <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         n_fault_d <= 1'b1;
         n_ack_d <= 1'b1;
      end else begin
         n_fault_d <= n_fault;
         n_ack_d <= n_ack;
      end
   end

   // automatic handshake engine
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hs <= EPE_IDLE;
         hold_cnt <= '0;
         out_byte <= '0;
         rle_left <= 8'h00;
      end else begin
         unique case (hs)
            EPE_IDLE: begin
               if (ecp_rev && !n_ack) hs <= EPE_REV_WAIT;
               else if (rle_left != 8'h00 && (ecp_fwd || pfifo_fwd)) begin
                  // repeats peek the queued data byte; the last copy pops it
                  out_byte <= '{cmd: 1'b0, data: head.data};
                  rle_left <= rle_left - 8'h01;
                  hold_cnt <= HOLD_CYC;
                  hs <= EPE_SETUP;
               end else if (fifo_pop && !host_rd_fifo && !dma_xfer) begin
                  if (head.cmd && !head.data[7] && mode == EPE_ECP) begin
                     rle_left <= head.data; // run-length count: expand locally
                  end else begin
                     out_byte <= head; // address commands go out
                     hold_cnt <= HOLD_CYC;
                     hs <= EPE_SETUP;
                  end
               end
            end
            EPE_SETUP: begin
               if (rle_left != 8'h00 || hs == EPE_SETUP) begin
                  if (hold_cnt != 2'h0) hold_cnt <= hold_cnt - 2'h1;
                  else if (!busy) hs <= EPE_STROBE;
               end
            end
            EPE_STROBE: if (busy) hs <= EPE_WAIT_REL;
            EPE_WAIT_REL: if (!busy) hs <= EPE_IDLE;
            EPE_REV_WAIT: if (fifo_push) hs <= EPE_REV_ACK;
            EPE_REV_ACK: if (n_ack) hs <= EPE_IDLE;
            default: hs <= EPE_IDLE;
         endcase
         if (!(ecp_fwd || pfifo_fwd || ecp_rev)) begin
            if (hs != EPE_IDLE) hs <= EPE_IDLE;
            rle_left <= 8'h00;
         end
      end
   end

   // pins
   always_comb begin
      n_strobe = ~dcr[DCR_STB];
      n_autofd = ~dcr[DCR_AFD];
      n_init = dcr[DCR_INIT];
      n_selectin = ~dcr[DCR_SELIN];
      pd_out = (fifo_on && mode != EPE_TEST) ? out_byte.data : (mode == EPE_TEST ? head.data : data_reg);
      pd_oe = !(dir && mode != EPE_SPP && mode != EPE_PFIFO);
      if (mode == EPE_ECP) begin
         n_selectin = 1'b1;
         n_init = ~dir;
         pd_oe = !dir && perror;
         if (ecp_fwd) begin
            n_autofd = ~out_byte.cmd;
            n_strobe = !(hs == EPE_STROBE);
         end else if (ecp_rev) begin
            n_autofd = !(hs == EPE_REV_ACK);
         end
      end else if (pfifo_fwd) begin
         n_strobe = !(hs == EPE_STROBE);
      end
   end

   assign dma_request_pin = dma_enable_bit && !service_flag && fifo_on &&
                            (dir ? !fifo_empty : !fifo_full);
   assign irq = service_flag || (mode == EPE_ECP && !nerr_en && !n_fault && !dir) ||
                (dcr[DCR_ACKIE] && n_ack && !n_ack_d);

   // register reads
   always_comb begin
      io_rdata = 8'h00;
      if (io.rd) begin
         unique case (io.addr)
            ADDR_DATA: io_rdata = dir ? pd_in : data_reg;
            ADDR_DSR: io_rdata = {~busy, n_ack, perror, select, n_fault, 3'h7} & ~{5'h00, ~DSR_LOW_ONES[2:0]};
            ADDR_DCR: io_rdata = {2'h3, dcr[5:0]};
            ADDR_DFIFO: io_rdata = (mode == EPE_CFG) ? CNFGA_VALUE : head.data;
            ADDR_CNFGB: io_rdata = {1'b0, irq, 3'h0, CNFGB_CONST[2:0]};
            ADDR_ECR: io_rdata = {mode, nerr_en, dma_enable_bit, service_flag, fifo_full, fifo_empty};
            default: io_rdata = 8'h00;
         endcase
      end
   end

   // extension floppy modes
   always_comb begin
      fdd_out = fdc_out;
      fdc_status_in = fdd_status_pins;
      if (single_extension_floppy_mode || dual_extension_floppy_mode) begin
         fdd_out.drive_b_motor_out = 1'b1;
         fdd_out.drive_b_select_out = 1'b1;
         fdc_status_in = fdd_status_pins | pd_in[4:0];
      end
      if (dual_extension_floppy_mode) begin
         fdd_out.drive_a_motor_out = 1'b1;
         fdd_out.drive_a_select_out = 1'b1;
      end
   end
endmodule : epe_port

// >>> verif/epe_port_asserts.sv
// port-level assertions for the ecp parallel port engine
`timescale 1ns/1ns
module epe_port_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // dma
   input wire logic dma_request_pin,
   input wire logic dma_ack,
   input wire logic dma_tc,
   input wire logic irq,
   // printer pins
   input wire logic [7:0] pd_in,
   input wire logic [7:0] pd_out,
   input wire logic pd_oe,
   input wire logic n_strobe,
   input wire logic n_autofd,
   input wire logic busy,
   input wire logic perror,
   // floppy extension
   input wire logic single_extension_floppy_mode,
   input wire logic dual_extension_floppy_mode,
   input wire logic [4:0] fdd_status_pins,
   input wire epe_pkg::epe_fdd_out_s fdd_out,
   input wire logic [4:0] fdc_status_in
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic fdd_any = single_extension_floppy_mode | dual_extension_floppy_mode;
   property p_fdd_single;
      single_extension_floppy_mode |-> fdd_out.drive_b_motor_out && fdd_out.drive_b_select_out;
   endproperty
   a_fdd_single: assert property (p_fdd_single) else $error("drive b active");
   property p_fdd_dual;
      dual_extension_floppy_mode |-> fdd_out == 4'hF;
   endproperty
   a_fdd_dual: assert property (p_fdd_dual) else $error("floppy drive active");
   property p_fdd_or;
      fdd_any |-> fdc_status_in == (fdd_status_pins | pd_in[4:0]);
   endproperty
   a_fdd_or: assert property (p_fdd_or) else $error("floppy status not ored");
   property p_tc_stop;
      dma_ack && dma_tc |=> !dma_request_pin;
   endproperty
   a_tc_stop: assert property (p_tc_stop) else $error("dma request after tc");
   property p_tc_irq;
      dma_ack && dma_tc |=> irq [*2];
   endproperty
   a_tc_irq: assert property (p_tc_irq) else $error("no irq after tc");
   property p_strobe_release;
      !n_strobe && busy |-> ##[1:2] n_strobe;
   endproperty
   a_strobe_release: assert property (p_strobe_release) else $error("strobe held");
   property p_strobe_setup;
      $fell(n_strobe) |-> $stable(pd_out) && $stable(n_autofd);
   endproperty
   a_strobe_setup: assert property (p_strobe_setup) else $error("data moved at strobe");
   property p_strobe_drive;
      !n_strobe |-> pd_oe && perror;
   endproperty
   a_strobe_drive: assert property (p_strobe_drive) else $error("strobe without drive");
   property p_oe_reverse;
      !perror && !$past(perror) |-> !pd_oe;
   endproperty
   a_oe_reverse: assert property (p_oe_reverse) else $error("bus driven in reverse");
   c_strobe: cover property ($fell(n_strobe));
   c_tc: cover property (dma_ack && dma_tc);
   c_fdd: cover property (dual_extension_floppy_mode);
   c_rev: cover property (!perror && !n_autofd);
endmodule : epe_port_asserts

bind epe_port epe_port_asserts epe_port_asserts_inst (.core_clk, .rst, .dma_request_pin, .dma_ack, .dma_tc, .irq,
   .pd_in, .pd_out, .pd_oe, .n_strobe, .n_autofd, .busy, .perror, .single_extension_floppy_mode,
   .dual_extension_floppy_mode, .fdd_status_pins, .fdd_out, .fdc_status_in);

// >>> verif/epe_printer_model.sv
// behavioural ecp peripheral on the printer pins
`timescale 1ns/1ns
module epe_printer_model (
   // clock
   input wire logic core_clk,
   // host side pins
   input wire logic [7:0] pd_out,
   input wire logic pd_oe,
   input wire logic n_strobe,
   input wire logic n_autofd,
   input wire logic n_init,
   // peripheral side pins
   output logic [7:0] pd_in = 8'h5A,
   output logic busy = 1'b0,
   output logic perror,
   output logic n_ack = 1'b1,
   output logic select,
   output logic n_fault = 1'b1
);
   logic [8:0] rx_q[$];
   logic [7:0] rev_byte = 8'h00;
   logic rev_drive = 1'b0;
   int slow = 0;
   assign perror = n_init;
   assign select = 1'b1;
   // released lines toggle so stale values never pass
   always @(posedge core_clk) pd_in <= pd_oe ? pd_out : (rev_drive ? rev_byte : ~pd_in);
   always @(negedge n_strobe) begin
      rx_q.push_back({~n_autofd, pd_out});
      repeat (slow) @(posedge core_clk);
      busy <= 1'b1;
      wait (n_strobe);
      @(posedge core_clk);
      busy <= 1'b0;
   end
   // one reverse byte; bit 8 set marks a command, whose msb is forced to zero
   task automatic send_rev(input logic [8:0] b);
      @(posedge core_clk);
      rev_byte <= b[8] ? {1'b0, b[6:0]} : b[7:0];
      rev_drive <= 1'b1;
      busy <= ~b[8];
      @(posedge core_clk);
      n_ack <= 1'b0;
      wait (!n_autofd);
      @(posedge core_clk);
      n_ack <= 1'b1;
      wait (n_autofd);
      rev_drive <= 1'b0;
      busy <= 1'b0;
   endtask : send_rev
endmodule : epe_printer_model

// >>> verif/test_epe_port.sv
// self-checking bench for the ecp parallel port engine
`timescale 1ns/1ns
module test_epe_port;
   import epe_pkg::*;
   localparam logic [5:0] MODE_ROWS [16] = '{6'h09, 6'h1B, 6'h33, 6'h00, 6'h12, 6'h22, 6'h09, 6'h24,
      6'h00, 6'h2D, 6'h09, 6'h36, 6'h00, 6'h3F, 6'h1F, 6'h09};
   localparam logic [8:0] FWD_EXP [5] = '{9'h0A5, 9'h185, 9'h03C, 9'h03C, 9'h03C};
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   epe_io_s io = '0;
   logic dma_ack = 1'b0, dma_tc = 1'b0, sgl = 1'b0, dual = 1'b0;
   epe_fdd_out_s fdc_out = '0;
   logic [4:0] fdd_status_pins = 5'h0A;
   logic [7:0] rdata, pd_in, pd_out, v;
   logic dreq, irq, pd_oe, n_strobe, n_autofd, n_init, n_selectin, n_ack, busy, perror, select, n_fault;
   epe_fdd_out_s fdd_out;
   logic [4:0] fdc_status_in;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   always #4 core_clk = ~core_clk;
   epe_port epe_port_inst (.core_clk, .rst, .io, .io_rdata(rdata), .dma_request_pin(dreq), .dma_ack, .dma_tc,
      .irq, .pd_in, .pd_out, .pd_oe, .n_strobe, .n_autofd, .n_init, .n_selectin, .n_ack, .busy, .perror, .select,
      .n_fault, .single_extension_floppy_mode(sgl), .dual_extension_floppy_mode(dual), .fdc_out,
      .fdd_status_pins, .fdd_out, .fdc_status_in);
   epe_printer_model epe_printer_model_inst (.core_clk, .pd_out, .pd_oe, .n_strobe, .n_autofd, .n_init,
      .pd_in, .busy, .perror, .n_ack, .select, .n_fault);
   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(negedge core_clk);
      io <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge core_clk);
      io <= '0;
   endtask : wr
   task automatic rd(input logic [10:0] a, output logic [7:0] d);
      @(negedge core_clk);
      io <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      #2 d = rdata;
      @(negedge core_clk);
      io <= '0;
   endtask : rd
   task automatic conclude();
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      rd(ADDR_ECR, v);
      chk("ecr reset", {1'b0, ECR_RESET}, {1'b0, v});
      chk("n_init reset", 9'h001, {8'h00, n_init});
      foreach (MODE_ROWS[i]) begin
         wr(ADDR_ECR, {MODE_ROWS[i][5:3], 5'h14});
         rd(ADDR_ECR, v);
         chk("ecr mode", {6'h00, MODE_ROWS[i][2:0]}, {6'h00, v[7:5]});
      end
      wr(ADDR_DCR, 8'h20);
      rd(ADDR_DCR, v);
      chk("dir in mode 1", 9'h001, {8'h00, v[DCR_DIR]});
      chk("n_init reverse", 9'h000, {8'h00, n_init});
      wr(ADDR_DCR, 8'h04);
      wr(ADDR_ECR, 8'h14);
      wr(ADDR_DCR, 8'h24);
      rd(ADDR_DCR, v);
      chk("dir in mode 0", 9'h000, {8'h00, v[DCR_DIR]});
      wr(ADDR_DCR, 8'h0C);
      wr(ADDR_ECR, 8'h74);
      epe_printer_model_inst.slow = 2;
      wr(ADDR_DFIFO, 8'hA5);
      wr(ADDR_AFIFO, 8'h85);
      wr(ADDR_AFIFO, 8'h02);
      wr(ADDR_DFIFO, 8'h3C);
      for (int k = 0; k < 300 && epe_printer_model_inst.rx_q.size() < 5; k++) @(negedge core_clk);
      repeat (10) @(negedge core_clk);
      chk("fwd count", 9'h005, 9'(epe_printer_model_inst.rx_q.size()));
      foreach (FWD_EXP[i]) chk("fwd byte", FWD_EXP[i], epe_printer_model_inst.rx_q[i]);
      chk("selectin", 9'h001, {8'h00, n_selectin});
      rd(ADDR_ECR, v);
      chk("drained", 9'h001, {8'h00, v[ECR_EMPTY]});
      wr(ADDR_ECR, 8'h34);
      wr(ADDR_DCR, 8'h24);
      wr(ADDR_ECR, 8'h74);
      chk("n_init ecp reverse", 9'h000, {8'h00, n_init});
      epe_printer_model_inst.send_rev(9'h0C3);
      epe_printer_model_inst.send_rev(9'h1C5);
      rd(ADDR_DFIFO, v);
      chk("rev data", 9'h0C3, {1'b0, v});
      rd(ADDR_DFIFO, v);
      chk("rev command", 9'h045, {1'b0, v});
      wr(ADDR_ECR, 8'h34);
      wr(ADDR_DCR, 8'h04);
      wr(ADDR_ECR, 8'h14);
      wr(ADDR_ECR, 8'hD4);
      for (int k = 0; k < 17; k++) wr(ADDR_DFIFO, 8'h40 + 8'(k));
      rd(ADDR_ECR, v);
      chk("full", 9'h002, {7'h00, v[ECR_FULL], v[ECR_EMPTY]});
      for (int k = 0; k < 16; k++) begin
         rd(ADDR_DFIFO, v);
         chk("fifo order", {1'b0, 8'h40 + 8'(k)}, {1'b0, v});
      end
      rd(ADDR_ECR, v);
      chk("empty", 9'h001, {8'h00, v[ECR_EMPTY]});
      wr(ADDR_ECR, 8'h14);
      wr(ADDR_ECR, 8'hC8);
      chk("dma request", 9'h001, {8'h00, dreq});
      @(negedge core_clk);
      dma_ack = 1'b1;
      io.wdata = 8'h77;
      @(negedge core_clk);
      dma_tc = 1'b1;
      @(negedge core_clk);
      dma_ack = 1'b0;
      dma_tc = 1'b0;
      chk("tc stop", 9'h001, {7'h00, dreq, irq});
      rd(ADDR_ECR, v);
      chk("service flag", 9'h001, {8'h00, v[ECR_SVC]});
      for (int k = 0; k < 2; k++) begin
         rd(ADDR_DFIFO, v);
         chk("dma byte", 9'h077, {1'b0, v});
      end
      wr(ADDR_ECR, 8'h14);
      wr(ADDR_ECR, 8'h70);
      repeat (2) @(negedge core_clk);
      chk("pio irq", 9'h001, {8'h00, irq});
      wr(ADDR_ECR, 8'h6C);
      wr(ADDR_ECR, 8'h68);
      chk("irq idle", 9'h000, {8'h00, irq});
      epe_printer_model_inst.n_fault = 1'b0;
      #1 chk("fault irq", 9'h001, {8'h00, irq});
      @(negedge core_clk);
      chk("fault pulse", 9'h000, {8'h00, irq});
      epe_printer_model_inst.n_fault = 1'b1;
      wr(ADDR_ECR, 8'h14);
      wr(ADDR_ECR, 8'hF4);
      rd(ADDR_DFIFO, v);
      chk("cnfga", {1'b0, CNFGA_VALUE}, {1'b0, v});
      sgl = 1'b1;
      #1 chk("single fdd", 9'h003, {5'h00, fdd_out});
      @(negedge core_clk);
      sgl = 1'b0;
      dual = 1'b1;
      #1 chk("dual fdd", 9'h00F, {5'h00, fdd_out});
      chk("fdd status", {4'h0, fdd_status_pins | pd_in[4:0]}, {4'h0, fdc_status_in});
      conclude();
   end
endmodule : test_epe_port
